// [common/sfrm_pkg.sv]
// Constants, field layout and carrier types of the register map decoder.
// Assumes one core clock; the core flags escape-prefixed accesses itself.
package sfrm_pkg;

	// Escape opcode that selects the extended set
	localparam logic [7:0] ESC_OPCODE   = 8'hA5;

	// Normal space
	localparam logic [7:0] ADR_PORT0    = 8'h80;
	localparam logic [7:0] ADR_STK_LO   = 8'h81;
	localparam logic [7:0] ADR_DP16_LO  = 8'h82;
	localparam logic [7:0] ADR_DP16_HI  = 8'h83;
	localparam logic [7:0] ADR_AUXF     = 8'h8E;
	localparam logic [7:0] ADR_PORT1    = 8'h90;
	localparam logic [7:0] ADR_AUXF2    = 8'hA2;
	localparam logic [7:0] ADR_WD_KICK  = 8'hA6;
	localparam logic [7:0] ADR_SPI_STAT = 8'hE1;
	localparam logic [7:0] ADR_PRIO1_HI = 8'hF7;
	localparam logic [7:0] ADR_CAP_LO0  = 8'hEA;
	localparam logic [7:0] ADR_CAP_LO4  = 8'hEE;
	localparam logic [7:0] ADR_CAP_HI0  = 8'hFA;
	localparam logic [7:0] ADR_CAP_HI4  = 8'hFE;
	// Extended space
	localparam logic [7:0] ADR_U1_STAT  = 8'h84;
	localparam logic [7:0] ADR_BG_CTRL  = 8'h85;
	localparam logic [7:0] ADR_BG_LO    = 8'h86;
	localparam logic [7:0] ADR_BG_HI    = 8'h87;
	localparam logic [7:0] ADR_WD_PRE   = 8'h8F;
	localparam logic [7:0] ADR_STK_HI   = 8'hFB;
	localparam logic [7:0] ADR_XP24_LO  = 8'hFC;
	localparam logic [7:0] ADR_XP24_MID = 8'hFD;
	localparam logic [7:0] ADR_XP24_HI  = 8'hFE;
	localparam logic [7:0] ADR_MEM_MODE = 8'hFF;

	// Reset values
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_PORT     = 8'hFF;
	localparam logic [7:0] RST_STK      = 8'h07;
	localparam logic [7:0] RST_WD_KICK  = 8'hFF;
	localparam logic [7:0] RST_POWER_ON = 8'h10;

	// Field positions
	localparam int BG_ENABLE_BIT  = 0;
	localparam int U0_SOURCE_BIT  = 1;
	localparam int BANK_SEL_BIT   = 0;
	localparam int HARD_ZERO_BIT  = 2;
	localparam int GEN_FLAG2_BIT  = 3;
	localparam int LP_PROM_BIT    = 4;
	localparam int U1_DBUF_BIT    = 7;
	localparam int U1_INTSEL_BIT  = 6;
	localparam int U1_CMBOFF_BIT  = 5;
	localparam int U1_DBIRQ_BIT   = 4;
	localparam int U1_FE_BIT      = 3;
	localparam int U1_BRK_BIT     = 2;
	localparam int U1_OVR_BIT     = 1;
	localparam int U1_STIRQ_BIT   = 0;
	localparam int SPI_PRIO_BIT   = 3;
	localparam int U1TX_PRIO_BIT  = 2;
	localparam int U0TX_PRIO_BIT  = 1;
	localparam int U1RX_PRIO_BIT  = 0;
	localparam int SPI_DONE_BIT   = 7;
	localparam int SPI_WCOL_BIT   = 6;

	// Boot sequencing for the reset-source capture; capture register count and half
	localparam logic [1:0] BOOT_LOAD = 2'd2;
	localparam logic [1:0] BOOT_DONE = 2'd3;
	localparam int         CAP_REGS  = 10;
	localparam int         CAP_HALF  = 5;

	typedef struct packed {
		logic [7:0] addr;
		logic       esc;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfrm_bus_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic       val;
	} sfrm_bit_t;

	typedef struct packed {
		logic u1_frame_err;
		logic u1_break;
		logic u1_overrun;
		logic spi_done;
		logic spi_wcol;
	} sfrm_hw_t;

	typedef struct packed {
		logic [7:0]  port0_latch;
		logic [7:0]  port1_latch;
		logic [15:0] stack_pointer16;
		logic [15:0] data_pointer16;
		logic [23:0] ext_pointer24;
		logic        baud_gen_enable;
		logic        uart0_baud_source;
		logic [15:0] baud_rate;
		logic        pointer_bank_select;
		logic        general_flag_two;
		logic        low_power_prom;
		logic [7:0]  uart1_status;
		logic [3:0]  prio1_high;
		logic [4:0]  mem_mode;
	} sfrm_out_t;

	// Writable bit mask; zero marks an undefined location or one of the ten capture bytes
	function automatic logic [7:0] sfr_mask(input logic ext, input logic [7:0] a);
		logic [7:0] m;
		m = 8'h00;
		if (ext) begin
			unique case (a)
				ADR_U1_STAT, ADR_BG_LO, ADR_BG_HI, ADR_STK_HI,
				ADR_XP24_LO, ADR_XP24_MID, ADR_XP24_HI: m = 8'hFF;
				ADR_BG_CTRL:  m = 8'h03;
				ADR_WD_PRE:   m = 8'h07;
				ADR_MEM_MODE: m = 8'h1F;
				default:      m = 8'h00;
			endcase
		end else begin
			unique case (a)
				8'h80, 8'h81, 8'h82, 8'h83, 8'h88, 8'h89, 8'h8A, 8'h8B,
				8'h8C, 8'h8D, 8'h90, 8'hA6, 8'hA8, 8'hC8, 8'hCC, 8'hCD,
				8'hE0, 8'hE2, 8'hE3, 8'hE9, 8'hF0, 8'hF9: m = 8'hFF;
				8'h8E:                      m = 8'h03;
				8'hA2:                      m = 8'h19;
				8'hB7, 8'hB8:               m = 8'h7F;
				8'hC9:                      m = 8'h3F;
				8'hD8:                      m = 8'hDF;
				8'hD9:                      m = 8'hC7;
				8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE: m = 8'h7F;
				8'hE1:                      m = 8'hC0;
				8'hE8, 8'hF7, 8'hF8:        m = 8'h0F;
				default:                    m = 8'h00;
			endcase
		end
		return m;
	endfunction

	function automatic logic is_capture(input logic ext, input logic [7:0] a);
		return !ext && ((a >= ADR_CAP_LO0 && a <= ADR_CAP_LO4) ||
			(a >= ADR_CAP_HI0 && a <= ADR_CAP_HI4));
	endfunction

endpackage

// [hdl/sfrm_decoder.sv]
// Special function register bank: normal and escape-selected extended set.
// Assumes the core presents one access per cycle, flags escape-prefixed
// instructions on esc, and drives reset_was_power_i from the reset logic.
// How it works
// - Stack pointer low byte at 81h resets to 07h; extended high byte extends it.
// - Unimplemented bits reset to zero; software must not write ones there.
// - 16-bit data pointer is high byte 83h and low byte 82h, reset zero.
// - 24-bit extended pointer is extended FCh, FDh, FEh, each reset zero.
// - Extended 85h holds generator enable in bit 0, uart0 source in bit 1.
// - Baud rate value: low byte extended 86h, high byte 87h, reset zero.
// - A2h: bank select bit 0, zero bit 2, flag bit 3, prom bit 4.
// - Extended 84h holds uart1 mode, select, error, break, overrun, enable bits.
// - F7h holds spi, uart1 tx, uart0 tx, uart1 rx high priority bits.
`timescale 1ns/1ps

module sfrm_decoder
	import sfrm_pkg::*;
(
	// Clock and reset
	input  wire logic      ref_clk_i,
	input  wire logic      rst_n_i,
	input  wire logic      reset_was_power_i,
	// Byte access from the core
	input  wire sfrm_bus_t bus_i,
	output logic [7:0]     rdata_o,
	// Bit access from the core
	input  wire sfrm_bit_t bit_i,
	output logic           bit_rdata_o,
	// Peripheral status events
	input  wire sfrm_hw_t  hw_i,
	// Register contents towards the peripherals
	output sfrm_out_t      regs_o,
	output logic           ready_o
);

	typedef struct packed {
		logic [255:0][7:0] mem;
		logic [7:0]        rdata;
		logic              bit_rd;
		logic [1:0]        por_sync;
		logic [1:0]        boot;
	} sfrm_state_t;

	function automatic logic [255:0][7:0] reset_image();
		logic [255:0][7:0] img;
		img = '0;
		img[{1'b0, ADR_PORT0[6:0]}]   = RST_PORT;
		img[{1'b0, ADR_PORT1[6:0]}]   = RST_PORT;
		img[{1'b0, ADR_STK_LO[6:0]}]  = RST_STK;
		img[{1'b0, ADR_WD_KICK[6:0]}] = RST_WD_KICK;
		return img;
	endfunction

	localparam sfrm_state_t ST_RESET = '{
		mem:      reset_image(),
		rdata:    RST_ZERO,
		bit_rd:   1'b0,
		por_sync: 2'b00,
		boot:     2'b00
	};

	sfrm_state_t st;
	sfrm_state_t next_st;
	logic [7:0]  cap_mem [CAP_REGS];

	logic [7:0]  w_idx;
	logic [7:0]  w_mask;
	logic        w_cap;
	logic [7:0]  b_reg;
	logic [7:0]  b_idx;
	logic [7:0]  b_mask;
	logic [3:0]  cap_wi;
	logic [3:0]  cap_ri;
	logic [7:0]  u1_idx;
	logic [7:0]  spi_idx;
	logic [7:0]  pre_idx;

	// Index of a location: extended set in the upper half
	assign w_idx   = {bus_i.esc, bus_i.addr[6:0]};
	assign w_mask  = sfr_mask(bus_i.esc, bus_i.addr);
	assign w_cap   = is_capture(bus_i.esc, bus_i.addr);
	assign b_reg   = {bit_i.addr[7:3], 3'b000};
	assign b_idx   = {1'b0, b_reg[6:0]};
	assign b_mask  = sfr_mask(1'b0, b_reg);
	assign u1_idx  = {1'b1, ADR_U1_STAT[6:0]};
	assign spi_idx = {1'b0, ADR_SPI_STAT[6:0]};
	assign pre_idx = {1'b1, ADR_WD_PRE[6:0]};

	// Capture slot: low bytes 0..4, high bytes 5..9
	always_comb begin
		cap_wi = 4'(bus_i.addr[2:0]) - 4'd2;
		if (bus_i.addr[4]) begin
			cap_wi = cap_wi + 4'(CAP_HALF);
		end
		cap_ri = cap_wi;
	end

	always_comb begin
		next_st = st;
		// Reset source strap, sampled after release
		next_st.por_sync = {st.por_sync[0], reset_was_power_i};
		if (st.boot != BOOT_DONE) begin
			next_st.boot = st.boot + 2'd1;
		end
		if (st.boot == BOOT_LOAD) begin
			next_st.mem[pre_idx] = st.por_sync[1] ? RST_POWER_ON : RST_ZERO;
		end

		// Byte write; unimplemented and hard-zero bits keep their reset zero
		if (bus_i.wr && !w_cap) begin
			next_st.mem[w_idx] = (st.mem[w_idx] & ~w_mask) |
				(bus_i.wdata & w_mask);
		end

		// Single bit write, done after the byte write
		if (bit_i.wr && bit_i.addr[7] && b_mask[bit_i.addr[2:0]]) begin
			next_st.mem[b_idx][bit_i.addr[2:0]] = bit_i.val;
		end

		// Event flags: a set in the clearing cycle still lands
		if (hw_i.u1_frame_err) begin
			next_st.mem[u1_idx][U1_FE_BIT] = 1'b1;
		end
		if (hw_i.u1_break) begin
			next_st.mem[u1_idx][U1_BRK_BIT] = 1'b1;
		end
		if (hw_i.u1_overrun) begin
			next_st.mem[u1_idx][U1_OVR_BIT] = 1'b1;
		end
		if (hw_i.spi_done) begin
			next_st.mem[spi_idx][SPI_DONE_BIT] = 1'b1;
		end
		if (hw_i.spi_wcol) begin
			next_st.mem[spi_idx][SPI_WCOL_BIT] = 1'b1;
		end

		// Read data registered one cycle after the request
		if (bus_i.rd) begin
			next_st.rdata = w_cap ? cap_mem[cap_ri] : st.mem[w_idx];
		end
		if (bit_i.rd) begin
			next_st.bit_rd = bit_i.addr[7] & st.mem[b_idx][bit_i.addr[2:0]];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Capture bytes carry no reset, saving the reset tree on ten bytes
	always_ff @(posedge ref_clk_i) begin
		if (bus_i.wr && w_cap) begin
			cap_mem[cap_wi] <= bus_i.wdata;
		end
	end

	assign rdata_o     = st.rdata;
	assign bit_rdata_o = st.bit_rd;
	assign ready_o     = (st.boot == BOOT_DONE);

	// Peripheral views of the stored bytes
	always_comb begin
		regs_o.port0_latch       = st.mem[{1'b0, ADR_PORT0[6:0]}];
		regs_o.port1_latch       = st.mem[{1'b0, ADR_PORT1[6:0]}];
		regs_o.stack_pointer16   = {st.mem[{1'b1, ADR_STK_HI[6:0]}],
			st.mem[{1'b0, ADR_STK_LO[6:0]}]};
		regs_o.data_pointer16    = {st.mem[{1'b0, ADR_DP16_HI[6:0]}],
			st.mem[{1'b0, ADR_DP16_LO[6:0]}]};
		regs_o.ext_pointer24     = {st.mem[{1'b1, ADR_XP24_HI[6:0]}],
			st.mem[{1'b1, ADR_XP24_MID[6:0]}],
			st.mem[{1'b1, ADR_XP24_LO[6:0]}]};
		regs_o.baud_gen_enable   = st.mem[{1'b1, ADR_BG_CTRL[6:0]}][BG_ENABLE_BIT];
		regs_o.uart0_baud_source = st.mem[{1'b1, ADR_BG_CTRL[6:0]}][U0_SOURCE_BIT];
		// Rate taken as written; a write while enabled is unpredictable
		regs_o.baud_rate         = {st.mem[{1'b1, ADR_BG_HI[6:0]}],
			st.mem[{1'b1, ADR_BG_LO[6:0]}]};
		regs_o.pointer_bank_select =
			st.mem[{1'b0, ADR_AUXF2[6:0]}][BANK_SEL_BIT];
		regs_o.general_flag_two  = st.mem[{1'b0, ADR_AUXF2[6:0]}][GEN_FLAG2_BIT];
		regs_o.low_power_prom    = st.mem[{1'b0, ADR_AUXF2[6:0]}][LP_PROM_BIT];
		regs_o.uart1_status      = st.mem[u1_idx];
		regs_o.prio1_high        = st.mem[{1'b0, ADR_PRIO1_HI[6:0]}][3:0];
		regs_o.mem_mode          = st.mem[{1'b1, ADR_MEM_MODE[6:0]}][4:0];
	end

endmodule // sfrm_decoder

// [verification/sfrm_decoder_props.sv]
// Port-level checks of the register bank.
// Assumes a reset before traffic; bound onto every decoder instance.
`timescale 1ns/1ps
module sfrm_decoder_props
	import sfrm_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk_i,
	input wire logic       rst_n_i,
	input wire logic       reset_was_power_i,
	// Core side
	input wire sfrm_bus_t  bus_i,
	input wire logic [7:0] rdata_o,
	input wire sfrm_bit_t  bit_i,
	input wire logic       bit_rdata_o,
	input wire sfrm_hw_t   hw_i,
	// Register views
	input wire sfrm_out_t  regs_o,
	input wire logic       ready_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire wn = bus_i.wr && !bus_i.esc;
	wire we = bus_i.wr && bus_i.esc;

	a_reset_vals: assert property (
		$rose(ready_o) |-> regs_o.stack_pointer16[7:0] == 8'h07 &&
		regs_o.port0_latch == 8'hFF && regs_o.port1_latch == 8'hFF) else $error("reset values");
	a_read_stack: assert property (
		bus_i.rd && !bus_i.wr && !bus_i.esc && bus_i.addr == 8'h81
		|=> rdata_o == $past(regs_o.stack_pointer16[7:0])) else $error("stack read");
	a_data_pointer16_low: assert property (
		wn && bus_i.addr == 8'h82 |=> regs_o.data_pointer16 ==
		{$past(regs_o.data_pointer16[15:8]), $past(bus_i.wdata)}) else $error("data_pointer16 low");
	a_esc_ignored: assert property (
		wn && bus_i.addr == 8'hFC |=> $stable(regs_o.ext_pointer24)) else $error("esc space");
	a_ext_pointer24_low: assert property (
		we && bus_i.addr == 8'hFC |=> regs_o.ext_pointer24[7:0] == $past(bus_i.wdata))
		else $error("ext_pointer24 low");
	a_baud_ctrl: assert property (
		we && bus_i.addr == 8'h85 |=> {regs_o.uart0_baud_source, regs_o.baud_gen_enable}
		== $past(bus_i.wdata[1:0])) else $error("baud control");
	a_baud_high: assert property (
		we && bus_i.addr == 8'h87 |=> regs_o.baud_rate[15:8] == $past(bus_i.wdata))
		else $error("baud high");
	a_aux_two: assert property (
		wn && bus_i.addr == 8'hA2 |=> {regs_o.low_power_prom, regs_o.general_flag_two,
		regs_o.pointer_bank_select} == {$past(bus_i.wdata[4:3]), $past(bus_i.wdata[0])})
		else $error("aux two");
	a_uart1_flags: assert property (
		hw_i.u1_frame_err || hw_i.u1_break || hw_i.u1_overrun |=> (regs_o.uart1_status[3:1]
		& $past({hw_i.u1_frame_err, hw_i.u1_break, hw_i.u1_overrun})) ==
		$past({hw_i.u1_frame_err, hw_i.u1_break, hw_i.u1_overrun})) else $error("uart1 flags");
	a_prio_high: assert property (
		wn && bus_i.addr == 8'hF7 |=> regs_o.prio1_high == $past(bus_i.wdata[3:0]))
		else $error("prio high");
	a_bit_port1: assert property (
		bit_i.wr && bit_i.addr[7:3] == 5'b10010 && !bus_i.wr
		|=> regs_o.port1_latch[$past(bit_i.addr[2:0])] == $past(bit_i.val)) else $error("bit write");
endmodule // sfrm_decoder_props

bind sfrm_decoder sfrm_decoder_props u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.reset_was_power_i(reset_was_power_i), .bus_i(bus_i), .rdata_o(rdata_o), .bit_i(bit_i),
	.bit_rdata_o(bit_rdata_o), .hw_i(hw_i), .regs_o(regs_o), .ready_o(ready_o));

// [verification/sfrm_decoder_tb.sv]
// Random and corner-case bench of the register bank.
// Assumes the checker file binds itself; inputs move 1 ns after the edge.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module sfrm_decoder_tb;
	import sfrm_pkg::*;
	logic       ref_clk_i, rst_n_i, pwr, bit_rd, ready;
	logic [7:0] rdata, d;
	sfrm_bus_t  bus;
	sfrm_bit_t  bt;
	sfrm_hw_t   hw;
	sfrm_out_t  regs;
	int         failures, total_checks;
	// {esc, address, reset value}
	logic [16:0] rst_tbl [16] = '{17'h080FF, 17'h08107, 17'h08200, 17'h08300, 17'h090FF,
		17'h0A6FF, 17'h0A200, 17'h0F700, 17'h18400, 17'h18500, 17'h18600, 17'h18700,
		17'h1FC00, 17'h1FD00, 17'h1FE00, 17'h18F10};
	// {esc, address, writable mask}; control byte after the rate bytes keeps them legal
	logic [16:0] rw_tbl [13] = '{17'h186FF, 17'h187FF, 17'h18503, 17'h082FF, 17'h083FF,
		17'h1FCFF, 17'h1FDFF, 17'h1FEFF, 17'h0A219, 17'h0F70F, 17'h184FF, 17'h0EAFF, 17'h0FBFF};

	sfrm_decoder DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reset_was_power_i(pwr),
		.bus_i(bus), .rdata_o(rdata), .bit_i(bt), .bit_rdata_o(bit_rd), .hw_i(hw),
		.regs_o(regs), .ready_o(ready));

	task automatic cyc();
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic x, input logic [7:0] a, input logic [7:0] v);
		bus = '{a, x, 1'b1, 1'b0, v};
		cyc();
		bus = '0;
		cyc();
	endtask
	task automatic rd(input logic x, input logic [7:0] a, input logic [7:0] exp);
		bus = '{a, x, 1'b0, 1'b1, 8'h00};
		cyc();
		bus = '0;
		`CHK("rdata", exp, rdata)
		cyc();
	endtask
	task automatic bit_acc(input logic w, input logic [7:0] a, input logic v);
		bt = '{a, w, !w, v};
		cyc();
		bt = '0;
		if (!w) `CHK("bit_rdata", v, bit_rd)
		cyc();
	endtask
	task automatic do_reset(input logic p);
		rst_n_i = 0;
		pwr = p;
		repeat (16) cyc();
		rst_n_i = 1;
		repeat (4) cyc();
		`CHK("ready", 1'b1, ready)
	endtask
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		ref_clk_i = 0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// Whole run needs about 1280 cycles
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		failures++;
		wrap_up();
	end
	initial begin
		bus = '0; bt = '0; hw = '0; failures = 0; total_checks = 0;
		void'($urandom(32'hAAB3));
		do_reset(1'b1);
		foreach (rst_tbl[i]) rd(rst_tbl[i][16], rst_tbl[i][15:8], rst_tbl[i][7:0]);
		repeat (20) begin
			wr(1'b1, 8'h85, 8'h00);
			foreach (rw_tbl[i]) begin
				// Software keeps ones out of reserved bits
				d = 8'($urandom) & rw_tbl[i][7:0];
				wr(rw_tbl[i][16], rw_tbl[i][15:8], d);
				rd(rw_tbl[i][16], rw_tbl[i][15:8], d);
			end
		end
		wr(1'b0, 8'h82, 8'h3C);
		wr(1'b0, 8'hFC, 8'h3C);
		wr(1'b1, 8'hFC, 8'hC3);
		rd(1'b0, 8'hFC, 8'h3C);
		rd(1'b1, 8'hFC, 8'hC3);
		rd(1'b0, 8'h82, 8'h3C);
		`CHK("data_pointer16", 8'h3C, regs.data_pointer16[7:0])
		repeat (16) begin
			d = 8'($urandom);
			bit_acc(1'b1, {5'b10010, d[2:0]}, d[3]);
			bit_acc(1'b0, {5'b10010, d[2:0]}, d[3]);
			`CHK("port1", d[3], regs.port1_latch[d[2:0]])
			bit_acc(1'b0, {1'b0, d[6:0]}, 1'b0);
		end
		wr(1'b1, 8'h84, 8'h00);
		hw = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
		cyc();
		hw = '0;
		rd(1'b1, 8'h84, 8'h0A);
		rd(1'b0, 8'hE1, 8'hC0);
		d = 8'($urandom) & 8'h1F;
		wr(1'b1, 8'hFF, d);
		`CHK("mem_mode", d[4:0], regs.mem_mode)
		hw.u1_break = 1'b1;
		wr(1'b1, 8'h84, 8'h00);
		hw = '0;
		rd(1'b1, 8'h84, 8'h04);
		do_reset(1'b0);
		rd(1'b1, 8'h8F, 8'h00);
		rd(1'b0, 8'h82, 8'h00);
		rd(1'b0, 8'h90, 8'hFF);
		wrap_up();
	end
endmodule // sfrm_decoder_tb
